// [core/brk_pkg.sv]
// Purpose: shared constants and bus-carrier types of the break comparator unit
// Assumes: 32-bit register bus, byte addresses as laid out below
// Notes: one place for every offset and field position, and the reset values of all registers but the hit flags
package brk_pkg;

  localparam int NUM_CH = 4; // independent break channels

  // register byte addresses
  localparam logic [31:0] ADDR_OFS [NUM_CH] = '{32'hfffc0400, 32'hfffc0410,
                                                32'hfffc0420, 32'hfffc0430};
  localparam logic [31:0] MASK_OFS [NUM_CH] = '{32'hfffc0404, 32'hfffc0414,
                                                32'hfffc0424, 32'hfffc0434};
  localparam logic [31:0] COND_OFS [NUM_CH] = '{32'hfffc04a0, 32'hfffc04b0,
                                                32'hfffc04a4, 32'hfffc04b4};
  localparam logic [31:0] CTRL_OFS = 32'hfffc04c0;  // common control word
  localparam logic [31:0] TIMING_OFS = 32'hfffc04c4; // per-channel pc break timing
  localparam logic [31:0] HIT_OFS = 32'hfffc04c8;    // sticky match flags, write 1 to clear

  // reset values
  localparam logic [31:0] ADDR_RST = 32'h00000000;
  localparam logic [31:0] MASK_RST = 32'h00000000;
  localparam logic [15:0] COND_RST = 16'h0000;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [3:0] TIMING_RST = 4'h0;

  // cycle condition field positions
  localparam int IRQ_DIS_BIT = 13;
  localparam int MASTER_LSB = 8;
  localparam int BUS_LSB = 6;
  localparam int FD_LSB = 4;
  localparam int DIR_LSB = 2;
  localparam int SIZE_LSB = 0;
  localparam logic [15:0] COND_WMASK = 16'h27ff; // bits 15,14,12,11 stay zero

  // bus select codes; 01 and 11 both choose the processor-side bus
  localparam logic [1:0] BUS_NONE = 2'h0;
  localparam logic [1:0] BUS_INTERNAL = 2'h2;
  // fetch/data select codes
  localparam logic [1:0] FD_FETCH = 2'h1;
  // master one-hot positions
  localparam int MST_CPU = 0;
  localparam int MST_DMA = 1;
  localparam int MST_DTC = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // instruction fetch bus cycle
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [1:0] size;
  } brk_fetch_t;

  // memory-access bus cycle
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic write;
    logic [1:0] size;
  } brk_mem_t;

  // internal bus cycle, master one-hot: cpu, dma, dtc
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic write;
    logic [1:0] size;
    logic [2:0] master;
  } brk_ibus_t;

  // decoded register access
  typedef enum logic [2:0] {
    REG_NONE, REG_ADDR, REG_MASK, REG_COND, REG_CTRL, REG_TIMING, REG_HIT
  } brk_kind_t;

  typedef struct packed {
    brk_kind_t kind;
    logic [1:0] ch;
  } brk_sel_t;

endpackage : brk_pkg

// [core/brk_comparator.sv]
// Purpose: four-channel break comparator with an AXI4-Lite register slave
// Assumes: monitored buses come from logic on aclk; one cycle per bus beat
// Notes: aresetn is the power-on reset; manual_resetn keeps all settings

module brk_comparator (
  // single clock; aresetn is the power-on reset
  input wire logic aclk,
  input wire logic aresetn,
  // manual reset clears the break outputs only
  input wire logic manual_resetn,
  // register bus
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // monitored buses
  // driven on aclk, so read without a synchroniser
  input wire brk_pkg::brk_fetch_t fetch_address_bus,
  input wire brk_pkg::brk_mem_t memaccess_address_bus,
  input wire brk_pkg::brk_ibus_t internal_address_bus,
  // break outputs
  output logic [3:0] break_req,
  output logic [3:0] break_after,
  // pin pulse, not gated by the disable bit
  output logic break_trigger_out
);
  import brk_pkg::*;

  // decode a byte address into register kind and channel
  function automatic brk_sel_t decode(input logic [31:0] a);
    brk_sel_t s;
    s.kind = REG_NONE;
    s.ch = 2'h0;
    // channel tables share one layout
    for (int i = 0; i < NUM_CH; i++) begin
      if (a == ADDR_OFS[i]) begin
        s.kind = REG_ADDR;
        s.ch = i[1:0];
      end
      if (a == MASK_OFS[i]) begin
        s.kind = REG_MASK;
        s.ch = i[1:0];
      end
      if (a == COND_OFS[i]) begin
        s.kind = REG_COND;
        s.ch = i[1:0];
      end
    end
    // common registers carry no channel
    if (a == CTRL_OFS) s.kind = REG_CTRL;
    if (a == TIMING_OFS) s.kind = REG_TIMING;
    if (a == HIT_OFS) s.kind = REG_HIT;
    // an unknown address stays unmapped
    return s;
  endfunction : decode

  // merge write data into an old word by byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    // one strobe per byte lane
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = d[8*b +: 8];
    end
    // unstrobed bytes keep their old value
    return r;
  endfunction : merge

  // one bus beat against address, mask, direction and size settings
  function automatic logic beat_ok(input logic valid, input logic [31:0] addr,
                                   input logic wr, input logic [1:0] size,
                                   input logic [31:0] ba, input logic [31:0] bm,
                                   input logic [1:0] dir, input logic [1:0] sz);
    // each term is true when its field is off
    logic addr_ok;
    logic dir_ok;
    logic size_ok;
    addr_ok = ((addr ^ ba) & ~bm) == 32'h00000000;
    dir_ok = (dir == 2'h0) | (dir[0] & ~wr) | (dir[1] & wr);
    size_ok = (sz == 2'h0) | (sz == size);
    // an idle bus never counts
    return valid & addr_ok & dir_ok & size_ok;
  endfunction : beat_ok

  // settings; only the power-on reset touches them
  logic [31:0] addr_reg [NUM_CH]; // break address per channel
  logic [31:0] mask_reg [NUM_CH]; // address mask per channel
  logic [15:0] cond_reg [NUM_CH]; // cycle condition per channel
  // shared registers
  logic [31:0] ctrl_reg; // common control word, plain storage
  logic [3:0] timing_reg; // 1: pc break taken after the instruction
  logic [3:0] hit_reg; // sticky per-channel match flags
  // next flag value, set wins over clear
  logic [3:0] hit_next;

  // per-channel match this cycle
  logic [3:0] match;

  // write channel state
  logic aw_full_reg; // address held waiting for data
  logic w_full_reg; // data held waiting for address
  // payload held until its partner arrives
  logic [31:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  // ready and response flops drive the ports
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  // last write's response code
  logic [1:0] bresp_reg;
  // read channel state
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  // last read's response code
  logic [1:0] rresp_reg;
  // break output flops
  logic [3:0] req_reg;
  // pc break timing per channel
  logic [3:0] after_reg;
  // any-channel trigger pin
  logic trig_reg;

  // handshakes and the combined write
  wire aw_hs = s_axi_awvalid & awready_reg;
  wire w_hs = s_axi_wvalid & wready_reg;
  wire aw_have = aw_full_reg | aw_hs;
  wire w_have = w_full_reg | w_hs;
  wire do_write = aw_have & w_have; // address and data may come in either order
  // a held half wins over the live bus
  wire [31:0] wr_addr = aw_full_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_full_reg ? w_data_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_full_reg ? w_strb_reg : s_axi_wstrb;
  wire brk_sel_t wr_sel = decode(wr_addr);
  // a lone half waits in its holding flop
  wire aw_full_next = aw_have & ~do_write;
  wire w_full_next = w_have & ~do_write;
  wire bvalid_next = do_write | (bvalid_reg & ~s_axi_bready);
  // ready stays low while a word is held or a response is pending
  wire awready_next = ~aw_full_next & ~bvalid_next;
  wire wready_next = ~w_full_next & ~bvalid_next;
  // unmapped writes are dropped with an error
  wire [1:0] bresp_sel = (wr_sel.kind == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
  wire wr_en = do_write & (wr_sel.kind != REG_NONE);
  // condition word widened for the byte merge
  wire [31:0] wr_old_cond = {16'h0000, cond_reg[wr_sel.ch]};
  wire [31:0] wr_cond_word = merge(wr_old_cond, wr_data, wr_strb);
  // write one to clear; needs the byte 0 strobe
  wire [3:0] hit_clear = (wr_en & (wr_sel.kind == REG_HIT)) ?
                         (wr_data[3:0] & {4{wr_strb[0]}}) : 4'h0;

  // read decode
  wire ar_hs = s_axi_arvalid & arready_reg;
  wire brk_sel_t rd_sel = decode(s_axi_araddr);
  // read data stays until rready is seen
  wire rvalid_next = ar_hs | (rvalid_reg & ~s_axi_rready);
  wire arready_next = ~rvalid_next; // one read at a time
  // selected word before it is captured
  logic [31:0] rd_word;

  // read mux; unmapped addresses read zero with an error response
  always_comb begin
    case (rd_sel.kind)
      // per-channel registers
      REG_ADDR: rd_word = addr_reg[rd_sel.ch];
      REG_MASK: rd_word = mask_reg[rd_sel.ch];
      REG_COND: rd_word = {16'h0000, cond_reg[rd_sel.ch] & COND_WMASK};
      // shared registers
      REG_CTRL: rd_word = ctrl_reg;
      REG_TIMING: rd_word = {28'h0000000, timing_reg};
      REG_HIT: rd_word = {28'h0000000, hit_reg};
      // unmapped: zero, error in rresp
      default: rd_word = 32'h00000000;
    endcase
  end

  // write channel handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // readies come up one edge after release
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      // response code latched with the write
      if (do_write) bresp_reg <= bresp_sel;
    end
  end

  // held write address and data; no reset needed for the payload
  always_ff @(posedge aclk) begin
    // loaded only on a handshake
    if (aw_hs) aw_addr_reg <= s_axi_awaddr;
    if (w_hs) begin
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      // capture data as the address is taken
      if (ar_hs) begin
        rdata_reg <= rd_word;
        rresp_reg <= (rd_sel.kind == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  // per-channel settings and comparators
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    // write strobe for this channel's settings
    wire sel_here = wr_en & (wr_sel.ch == 2'(c));
    // condition fields of this channel
    wire [1:0] bus_f = cond_reg[c][BUS_LSB +: 2];
    wire [1:0] fd_f = cond_reg[c][FD_LSB +: 2];
    wire [1:0] dir_f = cond_reg[c][DIR_LSB +: 2];
    wire [1:0] sz_f = cond_reg[c][SIZE_LSB +: 2];
    wire [2:0] mst_f = cond_reg[c][MASTER_LSB +: 3];
    // 01 and 11 pick the processor side, 10 the internal bus, 00 nothing
    wire cbus_sel = (bus_f != BUS_NONE) & (bus_f != BUS_INTERNAL);
    wire ibus_sel = (bus_f == BUS_INTERNAL);
    // 00 leaves cycle type out, 11 allows either
    wire want_fetch = (fd_f != 2'h2);
    wire want_data = (fd_f != FD_FETCH);
    // fetches are always reads
    wire fetch_ok = beat_ok(fetch_address_bus.valid, fetch_address_bus.addr, 1'b0,
                            fetch_address_bus.size, addr_reg[c], mask_reg[c], dir_f, sz_f);
    // data beats carry their own direction
    wire mem_ok = beat_ok(memaccess_address_bus.valid, memaccess_address_bus.addr,
                          memaccess_address_bus.write, memaccess_address_bus.size,
                          addr_reg[c], mask_reg[c], dir_f, sz_f);
    // master bits only count on the internal bus; processor side is cpu only
    wire mst_ok = |(mst_f & internal_address_bus.master);
    // internal beat also needs a master bit
    wire ib_ok = beat_ok(internal_address_bus.valid, internal_address_bus.addr,
                         internal_address_bus.write, internal_address_bus.size,
                         addr_reg[c], mask_reg[c], dir_f, sz_f) & mst_ok;
    // fetch address against the fetch bus, data against memory access bus
    wire cbus_hit = cbus_sel & ((want_fetch & fetch_ok) | (want_data & mem_ok));
    // a fetch-only condition cannot match on the internal bus
    wire ibus_hit = ibus_sel & want_data & ib_ok;
    // either bus may raise the channel
    assign match[c] = cbus_hit | ibus_hit;

    // settings survive manual reset; power-on reset clears them
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        addr_reg[c] <= ADDR_RST;
        mask_reg[c] <= MASK_RST;
        cond_reg[c] <= COND_RST;
      end else if (sel_here) begin
        // byte strobes apply per register
        if (wr_sel.kind == REG_ADDR) addr_reg[c] <= merge(addr_reg[c], wr_data, wr_strb);
        if (wr_sel.kind == REG_MASK) mask_reg[c] <= merge(mask_reg[c], wr_data, wr_strb);
        // reserved bits are never stored
        if (wr_sel.kind == REG_COND) cond_reg[c] <= wr_cond_word[15:0] & COND_WMASK;
      end
    end
  end

  // common registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RST;
      timing_reg <= TIMING_RST;
    end else if (wr_en) begin
      // control word is storage only
      if (wr_sel.kind == REG_CTRL) ctrl_reg <= merge(ctrl_reg, wr_data, wr_strb);
      // timing bits live in byte 0
      if ((wr_sel.kind == REG_TIMING) & wr_strb[0]) timing_reg <= wr_data[3:0];
    end
  end

  // a match in the same cycle as its clear keeps the flag set
  assign hit_next = (hit_reg & ~hit_clear) | match;

  // sticky flags; kept through manual reset for post-mortem reading
  always_ff @(posedge aclk) begin
    // of the two resets, only power-on reset clears the flags
    if (!aresetn) hit_reg <= 4'h0;
    else hit_reg <= hit_next;
  end

  // break requests and trigger pin, one cycle after the matching beat
  always_ff @(posedge aclk) begin
    // either reset silences the outputs
    if (!aresetn || !manual_resetn) begin
      req_reg <= 4'h0;
      after_reg <= 4'h0;
      trig_reg <= 1'b0;
    end else begin
      // one request line per channel
      for (int c = 0; c < NUM_CH; c++) begin
        // request only while the channel's disable bit is clear
        req_reg[c] <= match[c] & ~cond_reg[c][IRQ_DIS_BIT];
      end
      // tells the core whether to stop before or after the instruction
      after_reg <= match & timing_reg;
      // trigger pin fires on any match, even with requests disabled
      trig_reg <= |match;
    end
  end

  // outputs straight from flops
  // register bus side
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  // break side
  assign break_req = req_reg;
  assign break_after = after_reg;
  assign break_trigger_out = trig_reg;

endmodule : brk_comparator

// [verification/brk_comparator_chk.sv]
// Purpose: port-level timing checks on the break comparator
// Assumes: one clock, aresetn synchronous and active low
// Notes: bound onto every brk_comparator instance at the foot of this file
module brk_comparator_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic manual_resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire brk_pkg::brk_fetch_t fetch_address_bus,
  input wire brk_pkg::brk_mem_t memaccess_address_bus,
  input wire brk_pkg::brk_ibus_t internal_address_bus,
  input wire logic [3:0] break_req,
  input wire logic [3:0] break_after,
  input wire logic break_trigger_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import brk_pkg::*;
  // a beat on any watched bus; break outputs need one the cycle before
  wire any_beat = fetch_address_bus.valid | memaccess_address_bus.valid
                  | internal_address_bus.valid;
  // lone internal beat naming no master: must never match
  wire ibus_none = internal_address_bus.valid && internal_address_bus.master == 3'h0
                   && !fetch_address_bus.valid && !memaccess_address_bus.valid;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  trig_on_req_a: assert property (|break_req |-> break_trigger_out)
    else $error("break request without trigger");
  after_on_trig_a: assert property (|break_after |-> break_trigger_out)
    else $error("pc break timing without trigger");
  trig_cause_a: assert property (break_trigger_out |-> $past(any_beat))
    else $error("trigger without a bus beat");
  no_master_a: assert property (ibus_none |=> !break_trigger_out)
    else $error("internal beat without master matched");
  mrst_clear_a: assert property (!manual_resetn |=> break_req == 4'h0
      && break_after == 4'h0 && !break_trigger_out)
    else $error("manual reset left break outputs set");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid && !s_axi_awready)
    else $error("write response missing");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
endmodule : brk_comparator_chk

bind brk_comparator brk_comparator_chk u_chk (
  .aclk, .aresetn, .manual_resetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .fetch_address_bus, .memaccess_address_bus, .internal_address_bus,
  .break_req, .break_after, .break_trigger_out
);

// [verification/brk_bus_model.sv]
// Purpose: processor core and bus masters driving the watched buses
// Assumes: bench asks for one beat per cycle by holding go
// Notes: idle address, direction and size lines flip every cycle so a stale beat is never seen as live
module brk_bus_model (
  input wire logic aclk,
  input wire logic go,
  input wire logic [1:0] kind,
  input wire logic [31:0] addr,
  input wire logic wr,
  input wire logic [1:0] size,
  input wire logic [2:0] mst,
  output brk_pkg::brk_fetch_t fetch_bus,
  output brk_pkg::brk_mem_t mem_bus,
  output brk_pkg::brk_ibus_t ibus_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  import brk_pkg::*;
  // kind picks the bus: 0 fetch, 1 memory access, 2 internal
  wire on_f = go && kind == 2'h0;
  wire on_m = go && kind == 2'h1;
  wire on_i = go && kind == 2'h2;
  initial begin
    fetch_bus = '0;
    mem_bus = '0;
    ibus_bus = '0;
  end
  // fetch only on the fetch bus, masters only on the internal bus
  always @(posedge aclk) begin
    fetch_bus <= on_f ? brk_fetch_t'{1'b1, addr, size}
                      : brk_fetch_t'{1'b0, ~fetch_bus.addr, ~fetch_bus.size};
    mem_bus <= on_m ? brk_mem_t'{1'b1, addr, wr, size}
                    : brk_mem_t'{1'b0, ~mem_bus.addr, ~mem_bus.write, ~mem_bus.size};
    ibus_bus <= on_i ? brk_ibus_t'{1'b1, addr, wr, size, mst}
                     : brk_ibus_t'{1'b0, ~ibus_bus.addr, ~ibus_bus.write, ~ibus_bus.size, 3'h0};
  end
endmodule : brk_bus_model

// [verification/brk_comparator_tb_top.sv]
// Purpose: self-checking bench for the break comparator
// Assumes: AXI4-Lite master tasks, bus beats through brk_bus_model
// Notes: reset values, condition mask and unmapped access first, then table rows, flags, retention and back-to-back cases
module brk_comparator_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import brk_pkg::*;
  // channel setup, one beat, expected trigger and request
  typedef struct packed {
    logic [1:0] ch;
    logic [15:0] cond;
    logic [31:0] ba;
    logic [31:0] bm;
    logic [1:0] kind;
    logic [31:0] a;
    logic wr;
    logic [1:0] sz;
    logic [2:0] mst;
    logic trig;
    logic req;
  } brk_row_t;
  logic aclk, aresetn, manual_resetn, go, wr_dir;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, addr;
  logic [3:0] s_axi_wstrb, break_req, break_after;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, break_trigger_out;
  logic [1:0] s_axi_bresp, s_axi_rresp, kind, sz;
  logic [2:0] mst;
  brk_fetch_t fbus;
  brk_mem_t mbus;
  brk_ibus_t ibus;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  // fetch rows keep address lsb zero
  brk_row_t rows [12] = '{
    '{2'h0, 16'h006b, 32'h10, 32'h0, 2'h1, 32'h10, 1'b1, 2'h3, 3'h1, 1'b1, 1'b1},
    '{2'h0, 16'h006b, 32'h10, 32'h0, 2'h1, 32'h10, 1'b0, 2'h3, 3'h1, 1'b0, 1'b0},
    '{2'h0, 16'h006b, 32'h10, 32'h0, 2'h1, 32'h10, 1'b1, 2'h1, 3'h1, 1'b0, 1'b0},
    '{2'h1, 16'h02a0, 32'h20, 32'h0, 2'h2, 32'h20, 1'b0, 2'h2, 3'h2, 1'b1, 1'b1},
    '{2'h1, 16'h02a0, 32'h20, 32'h0, 2'h2, 32'h20, 1'b0, 2'h2, 3'h1, 1'b0, 1'b0},
    '{2'h1, 16'h02a0, 32'h20, 32'h0, 2'h2, 32'h20, 1'b0, 2'h2, 3'h0, 1'b0, 1'b0},
    '{2'h2, 16'h0020, 32'h0, 32'h0, 2'h1, 32'h0, 1'b0, 2'h0, 3'h1, 1'b0, 1'b0},
    '{2'h3, 16'h00d0, 32'h30, 32'h0, 2'h0, 32'h30, 1'b0, 2'h3, 3'h1, 1'b1, 1'b1},
    '{2'h3, 16'h0790, 32'h30, 32'h0, 2'h2, 32'h30, 1'b0, 2'h3, 3'h7, 1'b0, 1'b0},
    '{2'h0, 16'h0060, 32'ha0, 32'hff, 2'h1, 32'hf4, 1'b0, 2'h2, 3'h1, 1'b1, 1'b1},
    '{2'h0, 16'h0060, 32'ha0, 32'h0, 2'h1, 32'hf4, 1'b0, 2'h2, 3'h1, 1'b0, 1'b0},
    '{2'h2, 16'h2060, 32'h40, 32'h0, 2'h1, 32'h40, 1'b1, 2'h1, 3'h1, 1'b1, 1'b0}};

  brk_comparator u_dut (.aclk, .aresetn, .manual_resetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fetch_address_bus(fbus),
    .memaccess_address_bus(mbus), .internal_address_bus(ibus), .break_req, .break_after,
    .break_trigger_out);
  brk_bus_model u_bus (.aclk, .go, .kind, .addr, .wr(wr_dir), .size(sz), .mst,
    .fetch_bus(fbus), .mem_bus(mbus), .ibus_bus(ibus));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // watchdog: a hang counts as a mismatch
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // write: offer address and data together, release each when taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", 32'(s_axi_bresp), 32'(er));
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr
  task automatic axi_rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    chk("rdata", s_axi_rdata, e);
    chk("rresp", 32'(s_axi_rresp), 32'(er));
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd
  // n beats back to back; each answer lands exactly one cycle after its beat
  task automatic beat(input int n, input logic [1:0] k, input logic [31:0] a, input logic w,
      input logic [1:0] s, input logic [2:0] m, input logic et, input logic [3:0] er,
      input logic [3:0] ea);
    go <= 1'b1;
    kind <= k;
    addr <= a;
    wr_dir <= w;
    sz <= s;
    mst <= m;
    for (int i = 0; i <= n; i++) begin
      @(posedge aclk);
      if (i == n - 1) go <= 1'b0;
      if (i > 0) begin
        #1;
        chk("trigger", 32'(break_trigger_out), 32'(et));
        chk("request", 32'(break_req), 32'(er));
        chk("after", 32'(break_after), 32'(ea));
      end
    end
    @(posedge aclk);
  endtask : beat
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    brk_row_t r;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, go, wr_dir} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, addr, kind, sz, mst} = '0;
    s_axi_wstrb = 4'hf;
    manual_resetn = 1'b1;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < NUM_CH; i++) begin
      axi_rd(ADDR_OFS[i], 32'h0, RESP_OKAY);
      axi_rd(MASK_OFS[i], 32'h0, RESP_OKAY);
      axi_rd(COND_OFS[i], 32'h0, RESP_OKAY);
    end
    axi_rd(CTRL_OFS, 32'h0, RESP_OKAY);
    axi_wr(COND_OFS[0], 32'hffffffff, RESP_OKAY);
    axi_rd(COND_OFS[0], 32'h000027ff, RESP_OKAY);
    axi_wr(COND_OFS[0], 32'h0, RESP_OKAY);
    axi_wr(32'hfffc04f0, 32'h1, RESP_SLVERR);
    axi_rd(32'hfffc04f0, 32'h0, RESP_SLVERR);
    foreach (rows[i]) begin
      r = rows[i];
      axi_wr(ADDR_OFS[r.ch], r.ba, RESP_OKAY);
      axi_wr(MASK_OFS[r.ch], r.bm, RESP_OKAY);
      axi_wr(COND_OFS[r.ch], {16'h0, r.cond}, RESP_OKAY);
      beat(1, r.kind, r.a, r.wr, r.sz, r.mst, r.trig, 4'(r.req) << r.ch, 4'h0);
      axi_wr(COND_OFS[r.ch], 32'h0, RESP_OKAY);
    end
    // every channel matched at least once in the table; ones written clear the flags
    axi_rd(HIT_OFS, 32'hf, RESP_OKAY);
    axi_wr(HIT_OFS, 32'hf, RESP_OKAY);
    axi_rd(HIT_OFS, 32'h0, RESP_OKAY);
    // settings survive a manual reset, then pc break after the instruction
    axi_wr(ADDR_OFS[3], 32'h70, RESP_OKAY);
    axi_wr(COND_OFS[3], 32'h00d0, RESP_OKAY);
    axi_wr(TIMING_OFS, 32'h8, RESP_OKAY);
    axi_rd(TIMING_OFS, 32'h8, RESP_OKAY);
    manual_resetn <= 1'b0;
    repeat (2) @(posedge aclk);
    manual_resetn <= 1'b1;
    @(posedge aclk);
    axi_rd(ADDR_OFS[3], 32'h70, RESP_OKAY);
    axi_rd(COND_OFS[3], 32'hd0, RESP_OKAY);
    beat(2, 2'h0, 32'h70, 1'b0, 2'h3, 3'h1, 1'b1, 4'h8, 4'h8);
    // a matching beat under manual reset raises nothing
    manual_resetn <= 1'b0;
    beat(1, 2'h0, 32'h70, 1'b0, 2'h3, 3'h1, 1'b0, 4'h0, 4'h0);
    manual_resetn <= 1'b1;
    // power-on reset in mid-run clears the settings again
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(ADDR_OFS[3], 32'h0, RESP_OKAY);
    report_and_stop();
  end
endmodule : brk_comparator_tb_top
